// ---- src/ddr_cmd_pkg.sv ----
// Purpose: Shared constants and types for the registered command decoder
// Assumes: 13 address bits, 2 bank bits, single clock
// Notes:   Mode field layout of the base and extended mode registers
package ddr_cmd_pkg;
  localparam int ADDR_W       = 13;
  localparam int BANK_W       = 2;
  localparam int ROW_CNT_W    = 13;
  localparam int OPMODE_LO    = 7;
  localparam int OPMODE_HI    = 12;
  localparam int DLL_RST_BIT  = 8;
  localparam int SETTINGS_HI  = 6;
  localparam int AP_BIT       = 10;
  localparam int EXT_DLL_BIT  = 0;
  localparam int EXT_DRV_BIT  = 1;
  localparam int EXT_FET_BIT  = 2;
  localparam logic [5:0] OPMODE_NORMAL  = 6'h00;
  localparam logic [5:0] OPMODE_DLL_RST = 6'h02;
  localparam logic [1:0] BANK_BASE      = 2'h0;
  localparam logic [1:0] BANK_EXT       = 2'h1;
  localparam logic [12:0] MODE_RESET    = 13'h0000;
  localparam logic [12:0] EXT_RESET     = 13'h0000;
  localparam int DLL_LOCK_CYCLES = 200;
  localparam int LOCK_CNT_W      = 8;

  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_BURST_STOP,
    CMD_PRECHARGE, CMD_AUTO_REFRESH, CMD_SELF_REFRESH, CMD_LOAD_MODE, CMD_ILLEGAL
  } cmd_t;
endpackage : ddr_cmd_pkg

// ---- src/cmd_reg_if.sv ----
// Purpose: Registered command/address bundle between capture stage and decoder
// Assumes: Single clock domain
// Notes:   Carries the pin image one edge after capture
`timescale 1ns/100ps
interface cmd_reg_if;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [1:0]  bank;
  logic [12:0] addr;
  modport source (output cke, cs_n, ras_n, cas_n, we_n, bank, addr);
  modport sink   (input  cke, cs_n, ras_n, cas_n, we_n, bank, addr);
endinterface : cmd_reg_if

// ---- src/cmd_capture.sv ----
// Purpose: Two-stage input synchroniser and one-cycle register delay for commands
// Assumes: Pins come from the controller, outside the clock domain
// Notes:   Idle value is deselect with CKE low
`timescale 1ns/100ps
module cmd_capture
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Pins
  input  wire logic        cke_pin,
  input  wire logic        cs_n_pin,
  input  wire logic        ras_n_pin,
  input  wire logic        cas_n_pin,
  input  wire logic        we_n_pin,
  input  wire logic [1:0]  bank_pin,
  input  wire logic [12:0] addr_pin,
  // Registered bundle
  cmd_reg_if.source        out
);
  logic [19:0] meta;
  logic [19:0] sync;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= 20'h78000;
      sync <= 20'h78000;
    end
    else
    begin
      meta <= {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, bank_pin, addr_pin};
      sync <= meta;
    end
  end

  // Register stage adds one cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      out.cke   <= 1'b0;
      out.cs_n  <= 1'b1;
      out.ras_n <= 1'b1;
      out.cas_n <= 1'b1;
      out.we_n  <= 1'b1;
      out.bank  <= 2'h0;
      out.addr  <= 13'h0000;
    end
    else
    begin
      out.cke   <= sync[19];
      out.cs_n  <= sync[18];
      out.ras_n <= sync[17];
      out.cas_n <= sync[16];
      out.we_n  <= sync[15];
      out.bank  <= sync[14:13];
      out.addr  <= sync[12:0];
    end
  end
endmodule : cmd_capture

// ---- src/ddr_cmd_mode_decoder.sv ----
// Purpose: Command decode and mode register handling for a registered module
// Assumes: Controller keeps the encodings it is allowed to use
// Notes:   Decoded commands are one-cycle pulses, all outputs registered
//
`timescale 1ns/100ps
module ddr_cmd_mode_decoder
(
  // Clock and reset
  input  wire logic                               clock,
  input  wire logic                               rstn,
  // Command pins
  input  wire logic                               cke_pin,
  input  wire logic                               cs_n_pin,
  input  wire logic                               ras_n_pin,
  input  wire logic                               cas_n_pin,
  input  wire logic                               we_n_pin,
  input  wire logic [ddr_cmd_pkg::BANK_W-1:0]     bank_pin,
  input  wire logic [ddr_cmd_pkg::ADDR_W-1:0]     addr_pin,
  // Write data mask path
  input  wire logic                               wr_data_valid,
  input  wire logic                               dm_pin,
  // Decoded command
  output logic [3:0]                              cmd_code,
  output logic                                    cmd_valid,
  output logic [ddr_cmd_pkg::BANK_W-1:0]          cmd_bank,
  output logic [ddr_cmd_pkg::ADDR_W-1:0]          cmd_addr,
  output logic                                    auto_precharge,
  output logic                                    precharge_all,
  output logic                                    burst_stop_illegal,
  // Refresh
  output logic [ddr_cmd_pkg::ROW_CNT_W-1:0]       refresh_row,
  output logic                                    self_refresh_active,
  // Mode state
  output logic [ddr_cmd_pkg::ADDR_W-1:0]          mode_reg,
  output logic [ddr_cmd_pkg::ADDR_W-1:0]          ext_mode_reg,
  output logic                                    dll_enabled,
  output logic                                    dll_reset_pulse,
  output logic                                    normal_mode,
  output logic                                    reserved_mode_load,
  output logic                                    dll_locked,
  output logic                                    read_too_early,
  output logic                                    drive_reduced,
  output logic                                    fet_switch_control_n,
  // Data mask result
  output logic                                    write_enable
);
  import ddr_cmd_pkg::*;

  // Lock count must fit the lock counter
  if (DLL_LOCK_CYCLES < 1 || DLL_LOCK_CYCLES >= (1 << LOCK_CNT_W))
  begin : g_lock_check
    $error("lock count does not fit its counter");
  end

  cmd_reg_if r ();

  cmd_capture u_capture
  (
    .clock     (clock),
    .rstn      (rstn),
    .cke_pin   (cke_pin),
    .cs_n_pin  (cs_n_pin),
    .ras_n_pin (ras_n_pin),
    .cas_n_pin (cas_n_pin),
    .we_n_pin  (we_n_pin),
    .bank_pin  (bank_pin),
    .addr_pin  (addr_pin),
    .out       (r.source)
  );

  function automatic cmd_t decode(input logic cke, input logic cs_n, input logic ras_n,
                                  input logic cas_n, input logic we_n);
    cmd_t c;
    c = CMD_ILLEGAL;
    if (cs_n)
      c = CMD_DESELECT;
    else
    begin
      case ({ras_n, cas_n, we_n})
        3'h7: c = CMD_NOP;
        3'h3: c = CMD_ACTIVE;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h6: c = CMD_BURST_STOP;
        3'h2: c = CMD_PRECHARGE;
        3'h1: c = cke ? CMD_AUTO_REFRESH : CMD_SELF_REFRESH;
        3'h0: c = CMD_LOAD_MODE;
        default: c = CMD_ILLEGAL;
      endcase
      if (!cke && c != CMD_SELF_REFRESH)
        c = CMD_ILLEGAL;
    end
    return c;
  endfunction : decode

  // Accepted mode load aimed at the given register bank
  function automatic logic load_to(input cmd_t c, input logic in_sr,
                                   input logic [BANK_W-1:0] b,
                                   input logic [BANK_W-1:0] target);
    return !in_sr && (c == CMD_LOAD_MODE) && (b == target);
  endfunction : load_to

  // Either refresh command
  function automatic logic is_refresh(input cmd_t c);
    return (c == CMD_AUTO_REFRESH) || (c == CMD_SELF_REFRESH);
  endfunction : is_refresh

  cmd_t cur;
  logic sr_now;
  logic [LOCK_CNT_W-1:0] lock_cnt;
  logic [LOCK_CNT_W-1:0] next_lock_cnt;
  logic [5:0] opmode;
  logic dll_enable_event;
  logic base_load;
  logic ext_load;
  logic bst_allowed;
  logic [1:0] mask_meta;
  logic [1:0] mask_sync;

  assign cur    = decode(r.cke, r.cs_n, r.ras_n, r.cas_n, r.we_n);
  assign opmode = r.addr[OPMODE_HI:OPMODE_LO];
  assign base_load = load_to(cur, sr_now, r.bank, BANK_BASE);
  assign ext_load  = load_to(cur, sr_now, r.bank, BANK_EXT);

  // Decoded command outputs
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_code           <= 4'h0;
      cmd_valid          <= 1'b0;
      cmd_bank           <= 2'h0;
      cmd_addr           <= 13'h0000;
      auto_precharge     <= 1'b0;
      precharge_all      <= 1'b0;
      burst_stop_illegal <= 1'b0;
    end
    else
    begin
      cmd_code  <= 4'(cur);
      cmd_valid <= (cur != CMD_DESELECT) && (cur != CMD_NOP) && (cur != CMD_ILLEGAL) && !sr_now;
      if (is_refresh(cur))
      begin
        cmd_bank <= 2'h0;
        cmd_addr <= 13'h0000;
      end
      else
      begin
        cmd_bank <= r.bank;
        cmd_addr <= r.addr;
      end
      auto_precharge <= (cur == CMD_READ || cur == CMD_WRITE) && r.addr[AP_BIT];
      precharge_all  <= (cur == CMD_PRECHARGE) && r.addr[AP_BIT];
      burst_stop_illegal <= (cur == CMD_BURST_STOP) && !bst_allowed;
    end
  end

  // Internal refresh row counter and self refresh state
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      refresh_row <= 13'h0000;
      sr_now      <= 1'b0;
    end
    else
    begin
      if (!sr_now && is_refresh(cur))
        refresh_row <= refresh_row + 13'h0001;
      if (cur == CMD_SELF_REFRESH && !sr_now)
        sr_now <= 1'b1;
      else if (sr_now && r.cke)
        sr_now <= 1'b0;
    end
  end

  assign self_refresh_active = sr_now;

  // Burst terminate is only legal after a read without auto precharge
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      bst_allowed <= 1'b0;
    else if (cur == CMD_READ)
      bst_allowed <= !r.addr[AP_BIT];
    else if (cur == CMD_WRITE || cur == CMD_BURST_STOP)
      bst_allowed <= 1'b0;
  end

  // Base mode register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_reg           <= MODE_RESET;
      dll_reset_pulse    <= 1'b0;
      normal_mode        <= 1'b0;
      reserved_mode_load <= 1'b0;
    end
    else
    begin
      dll_reset_pulse    <= 1'b0;
      reserved_mode_load <= 1'b0;
      mode_reg[DLL_RST_BIT] <= 1'b0;
      if (base_load)
      begin
        if (opmode == OPMODE_NORMAL)
        begin
          mode_reg    <= r.addr;
          normal_mode <= 1'b1;
        end
        else if (opmode == OPMODE_DLL_RST)
        begin
          mode_reg        <= r.addr;
          dll_reset_pulse <= 1'b1;
          normal_mode     <= 1'b0;
        end
        else
        begin
          mode_reg           <= r.addr;
          normal_mode        <= 1'b0;
          reserved_mode_load <= 1'b1;
        end
      end
      else if (!sr_now && cur == CMD_LOAD_MODE && r.bank != BANK_EXT)
        reserved_mode_load <= 1'b1;
    end
  end

  // Extended mode register, kept until reloaded
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ext_mode_reg <= EXT_RESET;
    else if (ext_load)
      ext_mode_reg <= r.addr;
  end

  // Extended bit 0 low means DLL enabled; drive bit selects reduced strength
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      dll_enabled   <= 1'b0;
      drive_reduced <= 1'b0;
    end
    else
    begin
      if (sr_now && r.cke)
        dll_enabled <= 1'b1;
      else if (ext_load)
        dll_enabled <= !r.addr[EXT_DLL_BIT];
      if (ext_load)
        drive_reduced <= r.addr[EXT_DRV_BIT];
    end
  end

  // FET switch control never driven active
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      fet_switch_control_n <= 1'b1;
    else
      fet_switch_control_n <= 1'b1;
  end

  // DLL lock wait counter: counts CKE-high cycles after any DLL enable
  assign dll_enable_event = (sr_now && r.cke) ||
                            (ext_load && !r.addr[EXT_DLL_BIT] && !dll_enabled);

  always_comb
  begin
    next_lock_cnt = lock_cnt;
    if (dll_enable_event)
      next_lock_cnt = '0;
    else if (dll_enabled && r.cke && lock_cnt != LOCK_CNT_W'(DLL_LOCK_CYCLES))
      next_lock_cnt = lock_cnt + 1'b1;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_cnt       <= '0;
      dll_locked     <= 1'b0;
      read_too_early <= 1'b0;
    end
    else
    begin
      lock_cnt       <= next_lock_cnt;
      dll_locked     <= dll_enabled && (next_lock_cnt == LOCK_CNT_W'(DLL_LOCK_CYCLES));
      read_too_early <= (cur == CMD_READ) && !dll_locked;
    end
  end

  // Mask pins pass two flip-flops before use
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mask_meta <= 2'h0;
      mask_sync <= 2'h0;
    end
    else
    begin
      mask_meta <= {wr_data_valid, dm_pin};
      mask_sync <= mask_meta;
    end
  end

  // Data mask: low writes, high inhibits
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      write_enable <= 1'b0;
    else
      write_enable <= mask_sync[1] && !mask_sync[0];
  end
endmodule : ddr_cmd_mode_decoder

// ---- sim/ddr_cmd_assertions.sv ----
// Purpose: Port checks on the command decoder
// Assumes: Controller keeps the legal encodings
// Notes:   Command pins sampled at one edge show at outputs four samples later, mask pins three
`timescale 1ns/100ps
module ddr_cmd_checker
  import ddr_cmd_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // Pins
  input wire logic        cke_pin,
  input wire logic        cs_n_pin,
  input wire logic        ras_n_pin,
  input wire logic        cas_n_pin,
  input wire logic        we_n_pin,
  input wire logic [1:0]  bank_pin,
  input wire logic [12:0] addr_pin,
  input wire logic        wr_data_valid,
  input wire logic        dm_pin,
  // Outputs
  input wire logic [3:0]  cmd_code,
  input wire logic        cmd_valid,
  input wire logic [12:0] cmd_addr,
  input wire logic        auto_precharge,
  input wire logic        precharge_all,
  input wire logic [12:0] refresh_row,
  input wire logic        self_refresh_active,
  input wire logic [12:0] mode_reg,
  input wire logic [12:0] ext_mode_reg,
  input wire logic        dll_enabled,
  input wire logic        dll_reset_pulse,
  input wire logic        normal_mode,
  input wire logic        drive_reduced,
  input wire logic        fet_switch_control_n,
  input wire logic        write_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire       live = cke_pin && !cs_n_pin && !self_refresh_active;
  wire [2:0] rcw  = {ras_n_pin, cas_n_pin, we_n_pin};
  sequence base_load_s; live && rcw == 3'h0 && bank_pin == BANK_BASE; endsequence
  sequence ext_load_s;  live && rcw == 3'h0 && bank_pin == BANK_EXT;  endsequence
  normal_load_a: assert property (base_load_s ##0 addr_pin[12:7] == OPMODE_NORMAL |-> ##4
    normal_mode && mode_reg == $past(addr_pin, 4) && cmd_code == 4'h9) else $error("normal load");
  dll_reset_a: assert property (base_load_s ##0 addr_pin[12:7] == OPMODE_DLL_RST |-> ##4
    dll_reset_pulse && !normal_mode ##1 !mode_reg[DLL_RST_BIT]) else $error("dll reset");
  ext_load_a: assert property (ext_load_s |-> ##4 ext_mode_reg == $past(addr_pin, 4) &&
    dll_enabled == !$past(addr_pin[0], 4) && drive_reduced == $past(addr_pin[1], 4))
    else $error("ext load");
  fet_fixed_a: assert property (fet_switch_control_n) else $error("fet output");
  idle_quiet_a: assert property (cke_pin && (cs_n_pin || rcw == 3'h7) |-> ##4 !cmd_valid)
    else $error("idle command");
  read_ap_a: assert property (live && rcw == 3'h5 && addr_pin[AP_BIT] |-> ##4
    cmd_code == 4'h3 && auto_precharge) else $error("read precharge");
  pre_all_a: assert property (live && rcw == 3'h2 && addr_pin[AP_BIT] |-> ##4
    cmd_code == 4'h6 && precharge_all) else $error("precharge all");
  refresh_step_a: assert property (live && rcw == 3'h1 |-> ##4 cmd_code == 4'h7 &&
    cmd_addr == 13'h0000 && refresh_row == $past(refresh_row) + 13'h0001)
    else $error("refresh");
  self_entry_a: assert property (!cke_pin && !cs_n_pin && rcw == 3'h1 &&
    !self_refresh_active |-> ##4 self_refresh_active) else $error("self refresh");
  data_mask_a: assert property (wr_data_valid |-> ##3 write_enable == !$past(dm_pin, 3))
    else $error("data mask");
endmodule : ddr_cmd_checker
bind ddr_cmd_mode_decoder ddr_cmd_checker i_chk (.clock, .rstn, .cke_pin, .cs_n_pin,
  .ras_n_pin, .cas_n_pin, .we_n_pin, .bank_pin, .addr_pin, .wr_data_valid, .dm_pin,
  .cmd_code, .cmd_valid, .cmd_addr, .auto_precharge, .precharge_all, .refresh_row,
  .self_refresh_active, .mode_reg, .ext_mode_reg, .dll_enabled, .dll_reset_pulse,
  .normal_mode, .drive_reduced, .fet_switch_control_n, .write_enable);

// ---- sim/ddr_ctrl_model.sv ----
// Purpose: Memory controller driving the command and mask pins
// Assumes: One command per call, deselect between commands
// Notes:   Released lines show the inverse of their last value, CS high and CKE at its idle value
`timescale 1ns/100ps
module ddr_ctrl_model
(
  // Clock
  input wire logic clock,
  // Pins
  output logic        cke_pin,
  output logic        cs_n_pin,
  output logic        ras_n_pin,
  output logic        cas_n_pin,
  output logic        we_n_pin,
  output logic [1:0]  bank_pin,
  output logic [12:0] addr_pin,
  output logic        wr_data_valid,
  output logic        dm_pin
);
  logic idle_cke;
  initial
  begin
    {idle_cke, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 6'h3F;
    {bank_pin, addr_pin, wr_data_valid, dm_pin} = 17'h00000;
  end
  // Listed encodings only, CKE low only for self refresh
  task issue(input logic [4:0] c, input logic [1:0] b, input logic [12:0] a);
    @(posedge clock);
    {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} <= c;
    bank_pin <= b;
    addr_pin <= a;
    @(posedge clock);
    cke_pin <= idle_cke;
    {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} <= {1'b1, ~c[2:0]};
    bank_pin <= ~b;
    addr_pin <= ~a;
  endtask : issue
  task set_cke(input logic v);
    @(posedge clock);
    cke_pin <= v;
    idle_cke = v;
  endtask : set_cke
  // Mask aligned with its data element
  task wdata(input logic dm);
    @(posedge clock);
    wr_data_valid <= 1'b1;
    dm_pin <= dm;
    @(posedge clock);
    wr_data_valid <= 1'b0;
    dm_pin <= ~dm;
  endtask : wdata
endmodule : ddr_ctrl_model

// ---- sim/test_ddr_cmd_mode_decoder.sv ----
// Purpose: Self-checking bench for the command decoder
// Assumes: Command outputs settle three edges after the pins are sampled, write enable two
// Notes:   Commands coded as cke, cs, ras, cas, we
`timescale 1ns/100ps
module test_ddr_cmd_mode_decoder;
  import ddr_cmd_pkg::*;
  localparam logic [4:0] LMR = 5'h10, REF = 5'h11, PRE = 5'h12, ACT = 5'h13;
  localparam logic [4:0] WR = 5'h14, RD = 5'h15, BST = 5'h16, NOP = 5'h17, DES = 5'h18;
  logic        clock, rstn, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin;
  logic        wr_data_valid, dm_pin, cmd_valid, auto_precharge, precharge_all;
  logic        burst_stop_illegal, self_refresh_active, dll_enabled, dll_reset_pulse;
  logic        normal_mode, reserved_mode_load, dll_locked, read_too_early;
  logic        drive_reduced, fet_switch_control_n, write_enable;
  logic [1:0]  bank_pin, cmd_bank;
  logic [3:0]  cmd_code;
  logic [12:0] addr_pin, cmd_addr, refresh_row, mode_reg, ext_mode_reg;
  int          err_count = 0, n_tests = 0;
  ddr_cmd_mode_decoder i_dut (.clock, .rstn, .cke_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin,
    .we_n_pin, .bank_pin, .addr_pin, .wr_data_valid, .dm_pin, .cmd_code, .cmd_valid,
    .cmd_bank, .cmd_addr, .auto_precharge, .precharge_all, .burst_stop_illegal,
    .refresh_row, .self_refresh_active, .mode_reg, .ext_mode_reg, .dll_enabled,
    .dll_reset_pulse, .normal_mode, .reserved_mode_load, .dll_locked, .read_too_early,
    .drive_reduced, .fet_switch_control_n, .write_enable);
  ddr_ctrl_model i_ctrl (.clock, .cke_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin, .we_n_pin,
    .bank_pin, .addr_pin, .wr_data_valid, .dm_pin);
  initial clock = 1'b0;
  always #20 clock = ~clock;
  task chk_bit(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task chk_vec(input string n, input logic [12:0] e, input logic [12:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_vec
  task go(input logic [4:0] c, input logic [1:0] b, input logic [12:0] a);
    i_ctrl.issue(c, b, a);
    repeat (3) @(posedge clock);
    #1;
  endtask : go
  task t_mode;
    chk_bit("fet", 1'b1, fet_switch_control_n);
    go(LMR, 2'h0, 13'h0033);
    chk_vec("mode", 13'h0033, mode_reg);
    chk_vec("code", 13'h0009, {9'h000, cmd_code});
    go(LMR, 2'h0, 13'h0145);
    chk_bit("dllrst", 1'b1, dll_reset_pulse);
    @(posedge clock);
    #1;
    chk_vec("selfclr", 13'h0045, mode_reg);
    go(LMR, 2'h0, 13'h0032);
    chk_bit("normal", 1'b1, normal_mode);
    go(LMR, 2'h0, 13'h0080);
    chk_bit("resmode", 1'b1, reserved_mode_load);
    go(LMR, 2'h2, 13'h0001);
    chk_bit("resbank", 1'b1, reserved_mode_load);
  endtask : t_mode
  task t_ext;
    go(LMR, 2'h1, 13'h0007);
    chk_vec("ext", 13'h0007, ext_mode_reg);
    chk_bit("dlloff", 1'b0, dll_enabled);
    chk_bit("drive", 1'b1, drive_reduced);
    chk_bit("fetbit", 1'b1, fet_switch_control_n);
    go(NOP, 2'h0, 13'h1FFF);
    chk_bit("nop", 1'b0, cmd_valid);
    go(DES, 2'h1, 13'h0000);
    chk_bit("des", 1'b0, cmd_valid);
    chk_vec("exthold", 13'h0007, ext_mode_reg);
  endtask : t_ext
  task t_lock;
    go(LMR, 2'h1, 13'h0000);
    chk_bit("dllon", 1'b1, dll_enabled);
    go(LMR, 2'h0, 13'h0100);
    go(RD, 2'h0, 13'h0400);
    chk_bit("early", 1'b1, read_too_early);
    chk_bit("rdap", 1'b1, auto_precharge);
    repeat (170) @(posedge clock);
    #1;
    chk_bit("unlocked", 1'b0, dll_locked);
    repeat (40) @(posedge clock);
    #1;
    chk_bit("locked", 1'b1, dll_locked);
  endtask : t_lock
  task t_cmds;
    logic [4:0]  c [6] = '{ACT, WR, RD, BST, PRE, PRE};
    logic [1:0]  b [6] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h1, 2'h2};
    logic [12:0] a [6] = '{13'h1ABC, 13'h0412, 13'h0005, 13'h0000, 13'h0400, 13'h0000};
    logic [3:0]  e [6] = '{4'h2, 4'h4, 4'h3, 4'h5, 4'h6, 4'h6};
    for (int i = 0; i < 6; i++)
    begin
      go(c[i], b[i], a[i]);
      chk_vec("cmd", {9'h000, e[i]}, {9'h000, cmd_code});
      chk_bit("valid", 1'b1, cmd_valid);
      chk_bit("ap", i == 1, auto_precharge);
      chk_bit("pall", i == 4, precharge_all);
      if (i < 3)
        chk_vec("addr", {a[i][12:0]}, cmd_addr);
      if (i != 4)
        chk_vec("bank", {11'h000, b[i]}, {11'h000, cmd_bank});
      if (i == 2)
        chk_bit("early2", 1'b0, read_too_early);
      if (i == 3)
        chk_bit("bst", 1'b0, burst_stop_illegal);
    end
  endtask : t_cmds
  task t_refresh;
    for (int i = 1; i < 3; i++)
    begin
      go(REF, 2'h3, 13'h1FFF);
      chk_vec("code", 13'h0007, {9'h000, cmd_code});
      chk_vec("row", i[12:0], refresh_row);
      chk_vec("raddr", 13'h0000, cmd_addr);
    end
    go(LMR, 2'h1, 13'h0001);
    i_ctrl.idle_cke = 1'b0;
    go(5'h01, 2'h0, 13'h0000);
    chk_bit("selfin", 1'b1, self_refresh_active);
    i_ctrl.set_cke(1'b1);
    repeat (6) @(posedge clock);
    #1;
    chk_bit("selfout", 1'b0, self_refresh_active);
    chk_bit("dllauto", 1'b1, dll_enabled);
  endtask : t_refresh
  task t_mask;
    for (int i = 0; i < 2; i++)
    begin
      i_ctrl.wdata(i[0]);
      repeat (2) @(posedge clock);
      #1;
      chk_bit("wen", !i[0], write_enable);
    end
  endtask : t_mask
  task test_done;
    $display("Checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial
  begin
    rstn = 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    t_mode();
    t_ext();
    t_lock();
    t_cmds();
    t_refresh();
    t_mask();
    test_done();
  end
  initial
  begin
    #400000;
    err_count++;
    test_done();
  end
endmodule : test_ddr_cmd_mode_decoder
